//--- dv/sfc_config_regs_properties.sv
// Concurrent checks on the ports of the flash configuration register bank.
// Assumes it is bound into sfc_config_regs and shares its clk and reset_n.
`timescale 1ns/10ps
module sfc_config_regs_properties (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic spi_cs_n,
   input wire logic spi_so_oe,
   input wire logic soft_reset_req,
   input wire logic [31:0] cmd_addr,
   input wire logic [31:0] array_addr,
   input wire logic [7:0] erase_opcode,
   input wire logic [4:0] erase_size_log2,
   input wire logic [8:0] load_ptr,
   input wire logic [8:0] next_load_ptr,
   input wire logic erase_size_select,
   input wire logic page_wrap_select,
   input wire logic io3_role_select,
   input wire logic four_byte_addr_enable,
   input wire logic [31:0] boot_start_address,
   input wire logic boot_start
);
   wire logic [2:0] opts = {erase_size_select, page_wrap_select, io3_role_select};
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);
   ////////////////////////////////////////////////////////////////////////////
   oe_idle_a: assert property (spi_cs_n [*4] |-> !spi_so_oe)
      else $error("read driver on while deselected");
   // Option bits are one-time: once set they may never read back as clear.
   otp_keep_a: assert property ($past(reset_n) |-> (opts & $past(opts)) == $past(opts))
      else $error("option bit cleared");
   erase_uniform_a: assert property ($past(reset_n) && $past(erase_size_select) &&
      $past(erase_opcode) == 8'hd8 |-> erase_size_log2 == 5'h12)
      else $error("uniform erase size wrong");
   wrap_small_a: assert property ($past(reset_n) && !$past(page_wrap_select) |->
      next_load_ptr == (($past(load_ptr) & 9'h100) | (($past(load_ptr) + 9'h001) & 9'h0ff)))
      else $error("short page wrap wrong");
   wrap_full_a: assert property ($past(reset_n) && $past(page_wrap_select) |->
      next_load_ptr == $past(load_ptr) + 9'h001)
      else $error("full page wrap wrong");
   addr_bank_a: assert property ($past(reset_n) && !$past(four_byte_addr_enable) |->
      (array_addr & 32'hfcff_ffff) == ($past(cmd_addr) & 32'h00ff_ffff))
      else $error("banked address wrong");
   addr_wide_a: assert property ($past(reset_n) && $past(four_byte_addr_enable) |->
      array_addr == $past(cmd_addr))
      else $error("wide address wrong");
   wide_clear_a: assert property (soft_reset_req |-> ##[1:3] !four_byte_addr_enable)
      else $error("wide mode kept over reset");
   boot_pulse_a: assert property (boot_start |=> !boot_start)
      else $error("boot start longer than a cycle");
   boot_align_a: assert property (boot_start_address[8:0] == 9'h000)
      else $error("boot address not aligned");
endmodule // sfc_config_regs_properties

//--- dv/sfc_config_regs_test.sv
// Self-checking bench for the flash configuration register bank.
// Assumes the host model owns SCK, chip select and SI; IO3 and core-side inputs are driven here.
`timescale 1ns/10ps
bind sfc_config_regs sfc_config_regs_properties i_sfc_config_regs_properties (
   .clk, .reset_n, .spi_cs_n, .spi_so_oe, .soft_reset_req, .cmd_addr, .array_addr,
   .erase_opcode, .erase_size_log2, .load_ptr, .next_load_ptr, .erase_size_select,
   .page_wrap_select, .io3_role_select, .four_byte_addr_enable, .boot_start_address,
   .boot_start
);
module sfc_config_regs_test;
   logic clk = 1'b0;
   logic reset_n = 1'b0;
   logic spi_io3 = 1'b1;
   logic soft_reset_req = 1'b0;
   logic erase_suspended = 1'b0;
   logic program_suspended = 1'b0;
   logic params_at_top = 1'b0;
   logic [31:0] cmd_addr = 32'h0;
   logic [7:0] erase_opcode = 8'h0;
   logic [31:0] erase_addr = 32'h0;
   logic [8:0] load_ptr = 9'h0;
   logic spi_sck, spi_cs_n, spi_si, spi_so, spi_so_oe, hold_active;
   logic [31:0] array_addr, erase_base_addr, boot_start_address;
   logic [4:0] erase_size_log2;
   logic [8:0] next_load_ptr;
   logic [7:0] boot_start_delay;
   logic erase_valid, erase_size_select, page_wrap_select, io3_role_select;
   logic four_byte_addr_enable, boot_start;
   logic [63:0] rx;
   int errors = 0;
   int checks = 0;
   sfc_config_regs i_sfc_config_regs (
      .clk, .reset_n, .spi_sck, .spi_cs_n, .spi_si, .spi_io3, .spi_so, .spi_so_oe,
      .soft_reset_req, .erase_suspended, .program_suspended, .params_at_top,
      .cmd_addr, .array_addr, .erase_opcode, .erase_addr, .erase_base_addr,
      .erase_size_log2, .erase_valid, .load_ptr, .next_load_ptr, .erase_size_select,
      .page_wrap_select, .io3_role_select, .hold_active, .four_byte_addr_enable,
      .boot_start_address, .boot_start_delay, .boot_start
   );
   sfc_host_model i_sfc_host_model (.clk, .spi_sck, .spi_cs_n, .spi_si, .spi_so);
   initial begin
      forever #50 clk = ~clk;
   end
   ////////////////////////////////////////////////////////////////////////////
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         errors++;
         $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic test_done();
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task automatic xf(input logic [63:0] tx, input int n);
      i_sfc_host_model.frame(tx, n, rx);
   endtask
   task automatic rd(input logic [7:0] op, input int n);
      xf({op, 56'h0}, n);
   endtask
   // The window is bounded, so a missing or stretched pulse shows as a wrong count.
   task automatic boot_seen(input int exp);
      int hits;
      hits = 0;
      repeat (12) begin
         tick(1);
         if (boot_start === 1'b1) hits++;
      end
      chk(hits, exp);
   endtask
   task automatic ptr(input logic [8:0] p, input logic [8:0] e);
      load_ptr = p;
      tick(2);
      chk(next_load_ptr, e);
   endtask
   task automatic er(input logic [7:0] op, input logic [31:0] a, input logic [31:0] b,
                     input logic [4:0] lg, input logic v);
      erase_opcode = op;
      erase_addr = a;
      tick(2);
      chk(erase_valid, v);
      if (v) begin
         chk(erase_base_addr, b);
         chk(erase_size_log2, lg);
      end
   endtask
   task automatic soft_reset(input int exp);
      soft_reset_req = 1'b1;
      tick(1);
      soft_reset_req = 1'b0;
      boot_seen(exp);
   endtask
   ////////////////////////////////////////////////////////////////////////////
   task automatic t_reset();
      rd(8'h07, 16);
      chk(rx[7:0], 8'h00);
      rd(8'h14, 40);
      chk(rx[31:0], 32'h0);
      rd(8'h16, 16);
      chk(rx[7:0], 8'h00);
      // With the default role a low IO3 in a selected frame only pauses the link.
      i_sfc_host_model.select(1'b0);
      tick(4);
      spi_io3 = 1'b0;
      tick(4);
      chk(hold_active, 1'b1);
      chk(spi_so_oe, 1'b0);
      spi_io3 = 1'b1;
      tick(4);
      chk(hold_active, 1'b0);
      i_sfc_host_model.select(1'b1);
      tick(6);
   endtask
   task automatic t_suspend();
      erase_suspended = 1'b1;
      rd(8'h07, 16);
      chk(rx[7:0], 8'h02);
      erase_suspended = 1'b0;
      program_suspended = 1'b1;
      rd(8'h07, 16);
      chk(rx[7:0], 8'h01);
      program_suspended = 1'b0;
   endtask
   task automatic t_sr2();
      ptr(9'h1ff, 9'h100);
      er(8'h20, 32'h0000_1234, 32'h0000_1000, 5'h0c, 1'b1);
      er(8'h20, 32'h0012_3456, 32'h0, 5'h0, 1'b0);
      params_at_top = 1'b1;
      er(8'h20, 32'h00ff_3456, 32'h00ff_3000, 5'h0c, 1'b1);
      er(8'hd8, 32'h0012_3456, 32'h0012_0000, 5'h10, 1'b1);
      xf({8'h01, 16'h0, 8'h40, 32'h0}, 24);
      rd(8'h07, 16);
      chk(rx[7:0], 8'h00);
      xf({8'h01, 16'h0, 8'h5f, 32'h0}, 32);
      rd(8'h07, 16);
      chk(rx[7:0], 8'h40);
      ptr(9'h0ff, 9'h100);
      xf({8'h01, 16'h0, 8'ha0, 32'h0}, 32);
      rd(8'h07, 16);
      chk(rx[7:0], 8'he0);
      chk(io3_role_select, 1'b1);
      er(8'hd8, 32'h0012_3456, 32'h0010_0000, 5'h12, 1'b1);
      er(8'h20, 32'h00ff_3456, 32'h0, 5'h0, 1'b0);
   endtask
   task automatic t_boot();
      xf({8'h15, 32'h0004_0a02, 24'h0}, 40);
      soft_reset(0);
      xf({8'h15, 32'h0004_0a03, 24'h0}, 40);
      rd(8'h14, 40);
      chk(rx[31:0], 32'h0004_0a03);
      chk(boot_start_address, 32'h0004_0a00);
      chk(boot_start_delay, 8'h01);
      soft_reset(1);
   endtask
   task automatic t_bank();
      xf({8'h17, 8'hff, 48'h0}, 16);
      rd(8'h16, 16);
      chk(rx[7:0], 8'h83);
      cmd_addr = 32'hab12_3456;
      tick(2);
      chk(array_addr, 32'hab12_3456);
      xf({8'h17, 8'h02, 48'h0}, 16);
      chk(array_addr, 32'h0212_3456);
      xf({8'hb9, 56'h0}, 8);
      xf({8'h01, 8'h81, 48'h0}, 16);
      rd(8'h16, 16);
      chk(rx[7:0], 8'h81);
      // A low IO3 while selected is link traffic and must not reset.
      i_sfc_host_model.select(1'b0);
      spi_io3 = 1'b0;
      tick(4);
      spi_io3 = 1'b1;
      tick(4);
      i_sfc_host_model.select(1'b1);
      boot_seen(0);
      chk(four_byte_addr_enable, 1'b1);
      spi_io3 = 1'b0;
      tick(4);
      spi_io3 = 1'b1;
      boot_seen(1);
      rd(8'h16, 16);
      chk(rx[7:0], 8'h00);
      rd(8'h07, 16);
      chk(rx[7:0], 8'he0);
   endtask
   initial begin
      tick(10);
      reset_n = 1'b1;
      tick(4);
      t_reset();
      t_suspend();
      t_sr2();
      t_boot();
      t_bank();
      test_done();
   end
endmodule // sfc_config_regs_test

//--- dv/sfc_host_model.sv
// Behavioural SPI host in mode 0, framing one register command per call.
// Assumes a 10 MHz clk; SCK has an 800 ns period and stands low between frames.
`timescale 1ns/10ps
module sfc_host_model (
   input wire logic clk,
   output logic spi_sck,
   output logic spi_cs_n,
   output logic spi_si,
   input wire logic spi_so
);
   initial begin
      spi_sck = 1'b0;
      spi_cs_n = 1'b1;
      spi_si = 1'b1;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   // Sends n bits from tx[63] down; read data is taken late in the high phase,
   // since the device only launches it a few clocks after the falling edge.
   task automatic frame(input logic [63:0] tx, input int n, output logic [63:0] rx);
      rx = 64'h0;
      spi_cs_n = 1'b0;
      for (int i = 0; i < n; i++) begin
         spi_si = tx[63-i];
         tick(4);
         spi_sck = 1'b1;
         tick(4);
         rx = {rx[62:0], spi_so};
         spi_sck = 1'b0;
      end
      tick(4);
      spi_cs_n = 1'b1;
      // A released data line keeps no value, so show the inverse of the last bit.
      spi_si = ~spi_si;
      tick(6);
   endtask
   // Selects or releases the part with no clocking, for tests of the IO3 roles.
   task automatic select(input logic cs_n_value);
      spi_cs_n = cs_n_value;
   endtask
endmodule // sfc_host_model

//--- verilog/sfc_config_regs.sv
// Configuration and status registers of a serial flash, reached over SPI.
// Assumes SPI modes 0/3 with an SCK far slower than clk; the array core
// supplies suspend flags and consumes the decoded option outputs.
// Contract
// - Command 07h reads second status register.
// - OTP status bits change only via 24-bit WRITE_REGISTERS_CMD.
// - Bit 7 selects 256 KB uniform erase.
// - Hybrid mode: sixteen 4-KB sectors erased by 20h.
// - D8h erases 64 KB unit or 256 KB block.
// - Bit 6 selects 512B or 256B page wrap.
// - 256-byte wrap returns load address to zero; the code keeps bit 8, so 1FFh wraps to 100h.
// - Bit 5 makes IO3 reset, else hold.
// - IO3 resets only while not transferring data.
// - Bit 1 shows erase suspended, read-only.
// - Bit 0 shows program suspended, read-only.
// - Boot register read 14h, written 15h.
// - Enabled boot starts read on any reset; the code clears the enable on reset_n, so only IO3 and soft resets start it.
// - Boot register bit 0 enables boot read.
// - Bits 31:9 hold 512-byte aligned boot address.
// - Bits 8:1 hold boot start delay cycles.
// - Bank register via B9h, WRITE_REGISTERS_CMD, 16h, 17h.
// - Three-byte mode prefixes bank bits above A23.
// - Four-byte mode ignores bank bits.
// - Four-byte bit clears on every reset.
// - Bank bits 6:2 reserved zero, 1:0 reset zero.
`timescale 1ns/10ps
module sfc_config_regs
   import sfc_pkg::*;
#(
   parameter int ARRAY_ADDR_W = 24
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic spi_sck,
   input wire logic spi_cs_n,
   input wire logic spi_si,
   input wire logic spi_io3,
   output logic spi_so,
   output logic spi_so_oe,
   input wire logic soft_reset_req,
   input wire logic erase_suspended,
   input wire logic program_suspended,
   input wire logic params_at_top,
   input wire logic [31:0] cmd_addr,
   output logic [31:0] array_addr,
   input wire logic [7:0] erase_opcode,
   input wire logic [31:0] erase_addr,
   output logic [31:0] erase_base_addr,
   output logic [4:0] erase_size_log2,
   output logic erase_valid,
   input wire logic [8:0] load_ptr,
   output logic [8:0] next_load_ptr,
   output logic erase_size_select,
   output logic page_wrap_select,
   output logic io3_role_select,
   output logic hold_active,
   output logic four_byte_addr_enable,
   output logic [31:0] boot_start_address,
   output logic [7:0] boot_start_delay,
   output logic boot_start
);

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisation.
   logic [3:0] pin_level;
   logic [3:0] pin_rise;
   logic [3:0] pin_fall;

   // Reset values match the idle pins: IO3, chip select and data in high, clock low.
   sfc_sync #(
      .WIDTH(4),
      .INIT(4'he)
   ) u_sync (
      .clk(clk),
      .reset_n(reset_n),
      .pin({spi_io3, spi_cs_n, spi_si, spi_sck}),
      .level(pin_level),
      .rise(pin_rise),
      .fall(pin_fall)
   );

   logic sck_rise;
   logic sck_fall;
   logic si_level;
   logic cs_n_level;
   logic cs_rise;
   logic cs_fall;
   logic io3_level;

   assign sck_rise = pin_rise[0];
   assign sck_fall = pin_fall[0];
   assign si_level = pin_level[1];
   assign cs_n_level = pin_level[2];
   assign cs_rise = pin_rise[2];
   assign cs_fall = pin_fall[2];
   assign io3_level = pin_level[3];

   ////////////////////////////////////////////////////////////////////////////
   // Registers and reset events.
   logic [2:0] sr2_opt;
   logic [31:0] boot_reg;
   logic four_byte;
   logic [1:0] bank_bits;
   logic bank_access_pending;
   logic hw_reset;
   logic vol_reset;
   logic vol_reset_d;
   logic por_done;
   logic [7:0] sr2_value;
   logic [7:0] bank_value;

   // IO3 acts as reset only with the role bit set and the link idle.
   // Gating by chip select keeps a low data or hold level from wiping state mid-frame.
   assign hw_reset = io3_role_select & cs_n_level & ~io3_level;
   assign vol_reset = hw_reset | soft_reset_req;
   assign hold_active = ~io3_role_select & ~cs_n_level & ~io3_level;

   assign sr2_value = {sr2_opt, 3'h0, erase_suspended, program_suspended};
   assign bank_value = {four_byte, 5'h00, bank_bits};

   assign erase_size_select = sr2_opt[SFC_ERASE_SIZE_SELECT_POS-5];
   assign page_wrap_select = sr2_opt[SFC_PAGE_WRAP_SELECT_POS-5];
   assign io3_role_select = sr2_opt[SFC_IO3_ROLE_SELECT_POS-5];
   assign four_byte_addr_enable = four_byte;
   assign boot_start_address = {boot_reg[31:SFC_BOOT_ADDR_LSB], 9'h000};
   assign boot_start_delay = boot_reg[SFC_BOOT_ADDR_LSB-1:SFC_BOOT_DELAY_LSB];

   ////////////////////////////////////////////////////////////////////////////
   // SPI frame engine.
   sfc_frame_t frame;
   logic [5:0] bit_count;
   logic [7:0] opcode;
   logic [31:0] in_shift;
   logic [31:0] out_shift;
   logic shift_en;
   logic [7:0] next_opcode;

   // Hold freezes the shifter without ending the frame.
   assign shift_en = ~hold_active;
   assign next_opcode = {opcode[6:0], si_level};

   always_ff @(posedge clk) begin
      if (!reset_n || vol_reset || cs_n_level) begin
         frame <= SFC_IDLE;
      end else if (cs_fall) begin
         frame <= SFC_OPCODE;
      end else if (sck_rise && shift_en && frame == SFC_OPCODE &&
                   bit_count == SFC_OPCODE_BITS - 6'h01) begin
         case (next_opcode)
            SFC_READ_SECOND_STATUS_CMD,
            SFC_BOOT_REG_READ_CMD,
            SFC_BANK_REG_READ_CMD: frame <= SFC_DATA_OUT;
            default: frame <= SFC_DATA_IN;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n || cs_fall) begin
         bit_count <= 6'h00;
         opcode <= 8'h00;
         in_shift <= 32'h0000_0000;
      end else if (sck_rise && shift_en && frame != SFC_IDLE) begin
         if (bit_count != SFC_BIT_COUNT_MAX) begin
            bit_count <= bit_count + 6'h01;
         end
         if (frame == SFC_OPCODE) begin
            opcode <= next_opcode;
         end else begin
            in_shift <= {in_shift[30:0], si_level};
         end
      end
   end

   // Byte registers are replicated so rotation repeats them on long reads.
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         out_shift <= 32'h0000_0000;
      end else if (sck_rise && shift_en && frame == SFC_OPCODE &&
                   bit_count == SFC_OPCODE_BITS - 6'h01) begin
         case (next_opcode)
            SFC_READ_SECOND_STATUS_CMD: out_shift <= {4{sr2_value}};
            SFC_BOOT_REG_READ_CMD: out_shift <= boot_reg;
            SFC_BANK_REG_READ_CMD: out_shift <= {4{bank_value}};
            default: out_shift <= 32'h0000_0000;
         endcase
      end else if (sck_fall && shift_en && frame == SFC_DATA_OUT) begin
         out_shift <= {out_shift[30:0], out_shift[31]};
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n || cs_n_level) begin
         spi_so <= 1'b0;
      end else if (sck_fall && shift_en && frame == SFC_DATA_OUT) begin
         spi_so <= out_shift[31];
      end
   end

   assign spi_so_oe = (frame == SFC_DATA_OUT) & ~cs_n_level;

   ////////////////////////////////////////////////////////////////////////////
   // Register writes, committed at chip select rise on an exact bit count.
   // Committing at the frame end means an aborted or short frame writes nothing.
   logic commit_wrr_sr2;
   logic commit_boot;
   logic commit_bank;
   logic bank_reg_access_cmd_frame;

   assign bank_reg_access_cmd_frame = cs_rise && opcode == SFC_BANK_REG_ACCESS_CMD &&
                       bit_count == SFC_OPCODE_BITS;
   assign commit_wrr_sr2 = cs_rise && opcode == SFC_WRITE_REGISTERS_CMD &&
                           !bank_access_pending && bit_count == SFC_WRR_SR2_BITS;
   assign commit_boot = cs_rise && opcode == SFC_BOOT_REG_WRITE_CMD &&
                        bit_count == SFC_BOOT_WRITE_BITS;
   assign commit_bank = cs_rise && bit_count == SFC_BANK_WRITE_BITS &&
                        (opcode == SFC_BANK_REG_WRITE_CMD ||
                         (opcode == SFC_WRITE_REGISTERS_CMD && bank_access_pending));

   // Option bits behave as one-time programmable: they can only be set.
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         sr2_opt <= SFC_SR2_OPT_RESET;
      end else if (commit_wrr_sr2) begin
         sr2_opt <= sr2_opt | in_shift[SFC_ERASE_SIZE_SELECT_POS:SFC_IO3_ROLE_SELECT_POS];
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         boot_reg <= SFC_BOOT_RESET;
      end else if (commit_boot) begin
         boot_reg <= in_shift;
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n || vol_reset) begin
         four_byte <= SFC_BANK_RESET[SFC_FOUR_BYTE_POS];
         bank_bits <= SFC_BANK_RESET[1:0];
      end else if (commit_bank) begin
         four_byte <= in_shift[SFC_FOUR_BYTE_POS];
         bank_bits <= in_shift[1:0];
      end
   end

   // The access prefix arms only the very next frame.
   always_ff @(posedge clk) begin
      if (!reset_n || vol_reset) begin
         bank_access_pending <= 1'b0;
      end else if (cs_rise) begin
         bank_access_pending <= bank_reg_access_cmd_frame;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Boot start request on the release of an IO3 or soft reset; reset_n clears the enable bit first.
   // Waiting for the release lets the boot read start from settled option bits.
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         vol_reset_d <= 1'b0;
         por_done <= 1'b0;
         boot_start <= 1'b0;
      end else begin
         vol_reset_d <= vol_reset;
         por_done <= 1'b1;
         boot_start <= boot_reg[SFC_BOOT_ENABLE_POS] &
                       (~por_done | (vol_reset_d & ~vol_reset));
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Address extension for commands with a 3-byte address.
   // The result is registered, so the array sees it one cycle after cmd_addr.
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         array_addr <= 32'h0000_0000;
      end else if (four_byte) begin
         array_addr <= cmd_addr;
      end else begin
         array_addr <= {6'h00, bank_bits, cmd_addr[23:0]};
      end
   end

   // Page buffer load pointer: the 256-byte option keeps the page half bit.
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         next_load_ptr <= 9'h000;
      end else if (page_wrap_select) begin
         next_load_ptr <= load_ptr + 9'h001;
      end else begin
         next_load_ptr <= {load_ptr[8], load_ptr[7:0] + 8'h01};
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Erase geometry decode.
   // A small erase outside the parameter region is refused, never widened.
   logic in_param_region;
   logic [ARRAY_ADDR_W-17:0] sector_index;

   assign sector_index = erase_addr[ARRAY_ADDR_W-1:16];
   assign in_param_region = params_at_top ? (&sector_index) : (~|sector_index);

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         erase_base_addr <= 32'h0000_0000;
         erase_size_log2 <= 5'h00;
         erase_valid <= 1'b0;
      end else begin
         erase_base_addr <= erase_addr;
         erase_size_log2 <= 5'h00;
         erase_valid <= 1'b0;
         case (erase_opcode)
            SFC_SMALL_ERASE_CMD: begin
               // Small sectors exist only in the hybrid layout.
               if (!erase_size_select && in_param_region) begin
                  erase_base_addr <= {erase_addr[31:12], 12'h000};
                  erase_size_log2 <= SFC_SMALL_SECTOR_LOG2;
                  erase_valid <= 1'b1;
               end
            end
            SFC_BLOCK_ERASE_CMD: begin
               erase_valid <= 1'b1;
               if (erase_size_select) begin
                  erase_base_addr <= {erase_addr[31:18], 18'h00000};
                  erase_size_log2 <= SFC_UNIFORM_BLOCK_LOG2;
               end else begin
                  erase_base_addr <= {erase_addr[31:16], 16'h0000};
                  erase_size_log2 <= SFC_SECTOR_LOG2;
               end
            end
            default: begin
               erase_valid <= 1'b0;
            end
         endcase
      end
   end

endmodule // sfc_config_regs

//--- verilog/sfc_pkg.sv
// Package of the serial flash configuration register bank.
// Assumes a single 10 MHz system clock and an SPI link sampled by it.
package sfc_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Command opcodes.
   localparam logic [7:0] SFC_READ_SECOND_STATUS_CMD = 8'h07;
   localparam logic [7:0] SFC_WRITE_REGISTERS_CMD = 8'h01;
   localparam logic [7:0] SFC_BOOT_REG_READ_CMD = 8'h14;
   localparam logic [7:0] SFC_BOOT_REG_WRITE_CMD = 8'h15;
   localparam logic [7:0] SFC_BANK_REG_ACCESS_CMD = 8'hb9;
   localparam logic [7:0] SFC_BANK_REG_READ_CMD = 8'h16;
   localparam logic [7:0] SFC_BANK_REG_WRITE_CMD = 8'h17;
   localparam logic [7:0] SFC_SMALL_ERASE_CMD = 8'h20;
   localparam logic [7:0] SFC_BLOCK_ERASE_CMD = 8'hd8;

   ////////////////////////////////////////////////////////////////////////////
   // Second status register fields.
   localparam int SFC_ERASE_SIZE_SELECT_POS = 7;
   localparam int SFC_PAGE_WRAP_SELECT_POS = 6;
   localparam int SFC_IO3_ROLE_SELECT_POS = 5;
   localparam int SFC_ERASE_SUSPENDED_POS = 1;
   localparam int SFC_PROGRAM_SUSPENDED_POS = 0;
   localparam logic [2:0] SFC_SR2_OPT_RESET = 3'h0;

   // Boot register fields.
   localparam int SFC_BOOT_ADDR_LSB = 9;
   localparam int SFC_BOOT_DELAY_LSB = 1;
   localparam int SFC_BOOT_ENABLE_POS = 0;
   localparam logic [31:0] SFC_BOOT_RESET = 32'h0000_0000;

   // Bank register fields.
   localparam int SFC_FOUR_BYTE_POS = 7;
   localparam logic [7:0] SFC_BANK_RESET = 8'h00;

   ////////////////////////////////////////////////////////////////////////////
   // Frame bit counts: opcode plus data.
   localparam logic [5:0] SFC_OPCODE_BITS = 6'h08;
   localparam logic [5:0] SFC_WRR_SR2_BITS = 6'h20;
   localparam logic [5:0] SFC_BOOT_WRITE_BITS = 6'h28;
   localparam logic [5:0] SFC_BANK_WRITE_BITS = 6'h10;
   localparam logic [5:0] SFC_BIT_COUNT_MAX = 6'h3f;

   // Erase geometry, as log2 of byte counts.
   localparam logic [4:0] SFC_SMALL_SECTOR_LOG2 = 5'h0c;
   localparam logic [4:0] SFC_SECTOR_LOG2 = 5'h10;
   localparam logic [4:0] SFC_UNIFORM_BLOCK_LOG2 = 5'h12;

   typedef enum {
      SFC_IDLE,
      SFC_OPCODE,
      SFC_DATA_IN,
      SFC_DATA_OUT
   } sfc_frame_t;

endpackage

//--- verilog/sfc_sync.sv
// Two-flop synchroniser with edge detection for pins of the SPI link.
// Assumes inputs are asynchronous to clk; the first stage feeds only the second.
`timescale 1ns/10ps
module sfc_sync #(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] INIT = '0
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic [WIDTH-1:0] pin,
   output logic [WIDTH-1:0] level,
   output logic [WIDTH-1:0] rise,
   output logic [WIDTH-1:0] fall
);

   logic [WIDTH-1:0] stage1;
   logic [WIDTH-1:0] stage2;
   logic [WIDTH-1:0] stage3;

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         stage1 <= INIT;
         stage2 <= INIT;
         stage3 <= INIT;
      end else begin
         stage1 <= pin;
         stage2 <= stage1;
         stage3 <= stage2;
      end
   end

   assign level = stage2;
   assign rise = stage2 & ~stage3;
   assign fall = ~stage2 & stage3;

endmodule // sfc_sync
